// ---- src/rlc_repeat_loop_controller.sv ----
// Register access over APB and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module rlc_repeat_loop_controller
  import rlc_pkg::*;
#(
  parameter logic [RLC_PC_W-1:0] PROG_TOP = RLC_PROG_TOP_DEF
)
(
  input wire logic pclk, // Instruction-cycle clock
  input wire logic presetn, // Core reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB write
  input wire logic [RLC_ADDR_W-1:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic rep_issue, // Repeat instruction executes
  input wire logic rep_use_wreg, // Count from register operand
  input wire logic [RLC_CNT_W-1:0] immediate_count_field, // Literal count
  input wire logic [RLC_WREG_W-1:0] working_register_operand, // Register count
  input wire logic tgt_exec, // Repeated target executes once
  input wire logic tgt_is_psv, // Target reads through visibility window
  input wire logic exc_push_srl, // Exception entry pushes low byte
  input wire logic ret_start, // First cycle of return from interrupt
  input wire logic srl_pop, // Low byte popped on return
  input wire logic srl_pop_ra, // Popped repeat-active bit
  input wire logic [RLC_PC_W-1:0] pc_in, // PC of executing instruction
  input wire logic pc_valid, // pc_in is meaningful
  input wire logic do_issue, // Multi-instruction loop executes
  input wire logic do_use_wreg, // Multi loop count from register
  input wire logic [RLC_PC_W-1:0] do_end_in, // Multi loop end address
  input wire logic xw_valid, // Current instruction writes register
  input wire logic [RLC_REG_W-1:0] xw_reg, // Register written
  input wire logic xr_valid, // Instruction reads X via register address
  input wire logic [RLC_REG_W-1:0] xr_reg, // Address register read
  input wire logic ret_sub, // Subroutine return prefetch begins
  input wire logic [RLC_PC_W-1:0] ret_sub_pc, // Return target address
  output logic repeat_active_flag, // Repeat loop active
  output logic pc_hold, // Inhibit PC increment
  output logic [7:0] status_low_byte, // Low status byte for stacking
  output logic resume_prefetch, // Prefetch repeated instruction
  output logic psv_stall, // Extra cycle for window read
  output logic dep_stall, // Address dependency stall
  output logic addr_err_trap, // Illegal address error trap
  output logic do_active, // Multi loop active
  output logic do_reload, // Load PC with start address
  output logic [RLC_PC_W-1:0] do_reload_pc // Start address to load
);

  typedef struct packed {
    logic [RLC_CNT_W-1:0] repeat_loop_count;
    logic ra;
    rlc_ret_t ret_st;
    logic psv_first;
    logic prev_xw;
    logic [RLC_REG_W-1:0] prev_reg;
    logic dep_stall;
    logic psv_stall;
    logic resume_pf;
    logic trap;
    logic [RLC_CNT_W-1:0] multi_loop_count;
    logic [RLC_PC_W-1:0] dstart;
    logic [RLC_PC_W-1:0] dend;
    logic da;
    logic reload;
    logic [RLC_PC_W-1:0] reload_pc;
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
  } rlc_state_t;

  rlc_state_t state_r;
  rlc_state_t state_nxt;
  logic [RLC_CNT_W-1:0] rep_cnt;
  logic [RLC_CNT_W-1:0] do_cnt;
  logic apb_acc;
  logic apb_done;
  logic [RLC_STAT_W-1:0] status_word;
  logic [RLC_PC_W:0] ret_end;

  // Upper register bits beyond the counter width are ignored
  assign rep_cnt = rep_use_wreg ? working_register_operand[RLC_CNT_W-1:0]
                                : immediate_count_field;
  assign do_cnt = do_use_wreg ? working_register_operand[RLC_CNT_W-1:0]
                              : immediate_count_field;
  assign apb_acc = psel && penable && !state_r.pready;
  assign apb_done = psel && penable && state_r.pready;
  assign ret_end = {1'b0, ret_sub_pc} + RLC_PREFETCH_SPAN;

  always_comb
  begin
    status_word = '0;
    status_word[RLC_RA_BIT] = state_r.ra;
    status_word[RLC_DA_BIT] = state_r.da;
  end

  always_comb
  begin
    state_nxt = state_r;
    state_nxt.dep_stall = 1'b0;
    state_nxt.psv_stall = 1'b0;
    state_nxt.resume_pf = 1'b0;
    state_nxt.trap = 1'b0;
    state_nxt.reload = 1'b0;
    state_nxt.pready = 1'b0;
    state_nxt.pslverr = 1'b0;
    // Read data and ready are prepared at the first access edge
    if (apb_acc)
    begin
      state_nxt.pready = 1'b1;
      state_nxt.prdata = '0;
      unique case (paddr)
        RLC_ADDR_REPEAT_LOOP_COUNT:
          state_nxt.prdata[RLC_CNT_W-1:0] = state_r.repeat_loop_count;
        RLC_ADDR_STATUS:
          state_nxt.prdata[RLC_STAT_W-1:0] = status_word;
        RLC_ADDR_MULTI_LOOP_COUNT:
          state_nxt.prdata[RLC_CNT_W-1:0] = state_r.multi_loop_count;
        RLC_ADDR_DSTART:
          state_nxt.prdata[RLC_PC_W-1:0] = state_r.dstart;
        RLC_ADDR_DEND:
          state_nxt.prdata[RLC_PC_W-1:0] = state_r.dend;
        default:
          state_nxt.pslverr = 1'b1;
      endcase
    end
    // Writes land on the completing edge, before hardware updates so those win
    if (apb_done && pwrite && paddr == RLC_ADDR_REPEAT_LOOP_COUNT)
      state_nxt.repeat_loop_count = pwdata[RLC_CNT_W-1:0];
    if (apb_done && pwrite && paddr == RLC_ADDR_MULTI_LOOP_COUNT)
      state_nxt.multi_loop_count = pwdata[RLC_CNT_W-1:0];

    // Repeat loop: each target pass counts down, flag drops on the last
    if (rep_issue)
    begin
      state_nxt.repeat_loop_count = rep_cnt;
      state_nxt.ra = (rep_cnt != RLC_CNT_ZERO);
    end
    else if (tgt_exec && state_r.ra)
    begin
      if (state_r.repeat_loop_count == RLC_CNT_ZERO)
        state_nxt.ra = 1'b0;
      else
      begin
        state_nxt.repeat_loop_count = state_r.repeat_loop_count - RLC_CNT_ONE;
        if (state_r.repeat_loop_count == RLC_CNT_ONE)
          state_nxt.ra = 1'b0;
      end
    end
    if (exc_push_srl)
      state_nxt.ra = 1'b0;
    // A popped flag only resumes if the handler left iterations behind
    if (srl_pop)
      state_nxt.ra = srl_pop_ra && (state_r.repeat_loop_count != RLC_CNT_ZERO);
    // Return-from-interrupt sequencing
    unique case (state_r.ret_st)
      RLC_RET_IDLE:
        if (ret_start)
          state_nxt.ret_st = RLC_RET_C2;
      RLC_RET_C2:
      begin
        state_nxt.ret_st = RLC_RET_C3;
        state_nxt.resume_pf = state_nxt.ra;
        state_nxt.psv_first = state_nxt.ra;
      end
      RLC_RET_C3:
        state_nxt.ret_st = RLC_RET_IDLE;
      default:
        state_nxt.ret_st = RLC_RET_IDLE;
    endcase
    if (tgt_exec && state_r.psv_first)
    begin
      state_nxt.psv_first = 1'b0;
      state_nxt.psv_stall = tgt_is_psv;
    end
    // Read address register written by the previous X write
    state_nxt.prev_xw = xw_valid;
    state_nxt.prev_reg = xw_reg;
    if (xr_valid && state_r.prev_xw && (xr_reg == state_r.prev_reg))
      state_nxt.dep_stall = 1'b1;
    if (ret_sub && (ret_end > {1'b0, PROG_TOP}))
      state_nxt.trap = 1'b1;
    // Multi-instruction loop
    if (do_issue)
    begin
      state_nxt.multi_loop_count = do_cnt;
      state_nxt.dstart = pc_in + RLC_PC_STEP;
      state_nxt.dend = do_end_in;
      state_nxt.da = 1'b1;
    end
    else if (state_r.da && pc_valid && (pc_in == state_r.dend))
    begin
      if (state_r.multi_loop_count != RLC_CNT_ZERO)
      begin
        state_nxt.multi_loop_count = state_r.multi_loop_count - RLC_CNT_ONE;
        state_nxt.reload = 1'b1;
        state_nxt.reload_pc = state_r.dstart;
      end
      else
        state_nxt.da = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_r <= '0;
    else
      state_r <= state_nxt;
  end

  assign prdata = state_r.prdata;
  assign pready = state_r.pready;
  assign pslverr = state_r.pslverr;
  assign repeat_active_flag = state_r.ra;
  assign pc_hold = state_r.ra;
  assign status_low_byte = status_word[7:0];
  assign resume_prefetch = state_r.resume_pf;
  assign psv_stall = state_r.psv_stall;
  assign dep_stall = state_r.dep_stall;
  assign addr_err_trap = state_r.trap;
  assign do_active = state_r.da;
  assign do_reload = state_r.reload;
  assign do_reload_pc = state_r.reload_pc;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  rep_load_a: assert property (rep_issue |=> state_r.repeat_loop_count == $past(rep_cnt))
    else $error("repeat count not loaded");
  ra_set_a: assert property (rep_issue && rep_cnt != RLC_CNT_ZERO && !exc_push_srl
    && !srl_pop |=> repeat_active_flag && pc_hold)
    else $error("repeat flag not set");
  ra_zero_a: assert property (rep_issue && rep_cnt == RLC_CNT_ZERO && !srl_pop
    |=> !repeat_active_flag)
    else $error("zero count set flag");
  ra_ro_a: assert property (apb_done && pwrite && paddr == RLC_ADDR_STATUS
    && !rep_issue && !(tgt_exec && state_r.repeat_loop_count <= RLC_CNT_ONE)
    && !exc_push_srl && !srl_pop |=> $stable(repeat_active_flag))
    else $error("software changed repeat flag");
  rep_dec_a: assert property (tgt_exec && state_r.ra && state_r.repeat_loop_count > RLC_CNT_ONE
    && !rep_issue && !exc_push_srl && !srl_pop
    |=> state_r.repeat_loop_count == $past(state_r.repeat_loop_count) - RLC_CNT_ONE && pc_hold)
    else $error("repeat count not decremented");
  ra_end_a: assert property (tgt_exec && state_r.ra && state_r.repeat_loop_count == RLC_CNT_ONE
    && !rep_issue && !srl_pop |=> !pc_hold && state_r.repeat_loop_count == RLC_CNT_ZERO)
    else $error("repeat loop did not end");
  push_clr_a: assert property (exc_push_srl && !srl_pop |=> !repeat_active_flag)
    else $error("flag not cleared after push");
  status_a: assert property (status_low_byte[RLC_RA_BIT] == repeat_active_flag)
    else $error("stacked byte lacks repeat flag");
  pop_rest_a: assert property (srl_pop |=> repeat_active_flag ==
    ($past(srl_pop_ra) && $past(state_r.repeat_loop_count) != RLC_CNT_ZERO))
    else $error("popped flag not restored");
  ret_pf_a: assert property ($rose(resume_prefetch) |-> state_r.ret_st == RLC_RET_C3)
    else $error("prefetch outside third return cycle");
  ret_seq_a: assert property (ret_start && state_r.ret_st == RLC_RET_IDLE
    |=> state_r.ret_st == RLC_RET_C2 ##1 state_r.ret_st == RLC_RET_C3)
    else $error("return sequence wrong");
  psv_once_a: assert property (psv_stall |=> !psv_stall)
    else $error("window read stalled twice");
  dep_a: assert property (xr_valid && state_r.prev_xw && xr_reg == state_r.prev_reg
    |=> dep_stall ##1 (!dep_stall || $past(xr_valid)))
    else $error("dependency stall missing");
  trap_a: assert property (ret_sub && ret_end > {1'b0, PROG_TOP} |=> addr_err_trap)
    else $error("address trap missing");
  do_load_a: assert property (do_issue |=> do_active
    && state_r.dstart == $past(pc_in) + RLC_PC_STEP && state_r.dend == $past(do_end_in))
    else $error("multi loop not loaded");
  do_rel_a: assert property (state_r.da && pc_valid && pc_in == state_r.dend
    && !do_issue && state_r.multi_loop_count != RLC_CNT_ZERO
    |=> do_reload && do_reload_pc == $past(state_r.dstart))
    else $error("multi loop reload missing");
  do_end_a: assert property (state_r.da && pc_valid && pc_in == state_r.dend
    && !do_issue && state_r.multi_loop_count == RLC_CNT_ZERO |=> !do_active && !do_reload)
    else $error("multi loop did not end");
  apb_rdy_a: assert property (apb_acc |=> pready ##1 !pready)
    else $error("apb ready timing wrong");

endmodule // rlc_repeat_loop_controller

// ---- src/rlc_pkg.sv ----
package rlc_pkg;
  localparam int RLC_CNT_W = 14;
  localparam int RLC_PC_W = 24;
  localparam int RLC_WREG_W = 16;
  localparam int RLC_REG_W = 4;
  localparam int RLC_ADDR_W = 8;
  localparam int RLC_STAT_W = 16;
  localparam logic [RLC_ADDR_W-1:0] RLC_ADDR_REPEAT_LOOP_COUNT = 8'h00;
  localparam logic [RLC_ADDR_W-1:0] RLC_ADDR_STATUS = 8'h04;
  localparam logic [RLC_ADDR_W-1:0] RLC_ADDR_MULTI_LOOP_COUNT = 8'h08;
  localparam logic [RLC_ADDR_W-1:0] RLC_ADDR_DSTART = 8'h0C;
  localparam logic [RLC_ADDR_W-1:0] RLC_ADDR_DEND = 8'h10;
  localparam int RLC_RA_BIT = 4;
  localparam int RLC_DA_BIT = 9;
  localparam logic [RLC_PC_W-1:0] RLC_PC_STEP = 24'h000002;
  localparam logic [RLC_PC_W:0] RLC_PREFETCH_SPAN = 25'h0000004;
  localparam logic [RLC_PC_W-1:0] RLC_PROG_TOP_DEF = 24'h03FFFE;
  localparam logic [RLC_CNT_W-1:0] RLC_CNT_ZERO = 14'h0000;
  localparam logic [RLC_CNT_W-1:0] RLC_CNT_ONE = 14'h0001;
  typedef enum logic [1:0] {
    RLC_RET_IDLE = 2'b00,
    RLC_RET_C2 = 2'b01,
    RLC_RET_C3 = 2'b10
  } rlc_ret_t;
endpackage

// ---- testbench/rlc_core_model.sv ----
`timescale 1ns/1ps
module rlc_core_model
(
  input wire logic pclk, // Core clock
  input wire logic presetn, // Core reset
  input wire logic run, // Execute targets while looping
  input wire logic rep_issue, // Repeat instruction issued
  input wire logic repeat_active_flag, // Loop active
  output logic tgt_exec, // One target pass
  output logic [15:0] passes // Passes since last repeat
);
  // Target is a plain one-word instruction, never a restricted kind
  assign tgt_exec = run & repeat_active_flag;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      passes <= 16'h0000;
    else if (rep_issue)
      passes <= 16'h0000;
    else if (tgt_exec)
      passes <= passes + 16'h0001;
  end
endmodule // rlc_core_model

// ---- testbench/rlc_repeat_loop_controller_bench.sv ----
`timescale 1ns/1ps
module rlc_repeat_loop_controller_bench
  import rlc_pkg::*;
;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, run = 0, b_tgt = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, er, m_tgt, tgt_exec, tgt_is_psv = 0, rep_issue = 0, rep_use_wreg = 0;
  logic [RLC_CNT_W-1:0] immediate_count_field = 14'h0000;
  logic [RLC_WREG_W-1:0] working_register_operand = 16'h0000;
  logic exc_push_srl = 0, ret_start = 0, srl_pop = 0, srl_pop_ra = 0, pc_valid = 0;
  logic do_issue = 0, do_use_wreg = 0, xw_valid = 0, xr_valid = 0, ret_sub = 0;
  logic [RLC_PC_W-1:0] pc_in = 24'h0, do_end_in = 24'h0, ret_sub_pc = 24'h0, do_reload_pc;
  logic [RLC_REG_W-1:0] xw_reg = 4'h0, xr_reg = 4'h0;
  logic repeat_active_flag, pc_hold, resume_prefetch, psv_stall, dep_stall;
  logic addr_err_trap, do_active, do_reload;
  logic [7:0] status_low_byte;
  logic [15:0] passes;
  int miscompares = 0, tests_run = 0, n;
  assign tgt_exec = m_tgt | b_tgt;
  always #10 pclk = ~pclk;
  rlc_core_model core (.pclk, .presetn, .run, .rep_issue, .repeat_active_flag,
    .tgt_exec(m_tgt), .passes);
  rlc_repeat_loop_controller uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .rep_issue, .rep_use_wreg,
    .immediate_count_field, .working_register_operand, .tgt_exec, .tgt_is_psv,
    .exc_push_srl, .ret_start, .srl_pop, .srl_pop_ra, .pc_in, .pc_valid, .do_issue,
    .do_use_wreg, .do_end_in, .xw_valid, .xw_reg, .xr_valid, .xr_reg, .ret_sub,
    .ret_sub_pc, .repeat_active_flag, .pc_hold, .status_low_byte, .resume_prefetch,
    .psv_stall, .dep_stall, .addr_err_trap, .do_active, .do_reload, .do_reload_pc);
  task automatic results;
    $display("compares %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      miscompares++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Exception entry then return with the stacked flag set; ra picks whether the counter survives and is the flag expected after
  task automatic intr_ret(input logic ra);
    @(posedge pclk);
    exc_push_srl <= 1'b1;
    #1 chk(status_low_byte[4], 1);
    @(posedge pclk);
    exc_push_srl <= 1'b0;
    #1 chk(repeat_active_flag, 0);
    // Handler runs its own repeat, so it saves and restores the counter
    if (ra)
    begin
      apb(0, RLC_ADDR_REPEAT_LOOP_COUNT, 0);
      @(posedge pclk);
      rep_issue <= 1'b1;
      immediate_count_field <= 14'h0000;
      @(posedge pclk);
      rep_issue <= 1'b0;
      apb(1, RLC_ADDR_REPEAT_LOOP_COUNT, rd);
    end
    else
      apb(1, RLC_ADDR_REPEAT_LOOP_COUNT, 32'h0);
    @(posedge pclk);
    ret_start <= 1'b1;
    srl_pop <= 1'b1;
    srl_pop_ra <= 1'b1;
    @(posedge pclk);
    ret_start <= 1'b0;
    srl_pop <= 1'b0;
    #1 chk(repeat_active_flag, ra);
    @(posedge pclk);
    #1 chk(resume_prefetch, ra);
  endtask
  initial
  begin
    #100000;
    miscompares++;
    results();
  end
  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, RLC_ADDR_STATUS, 0);
    chk(rd, 0);
    apb(1, 8'h20, 32'hFFFFFFFF);
    chk(er, 1);
    apb(0, 8'h20, 0);
    chk(er, 1);
    chk(rd, 0);
    $display("test registers done");
    @(posedge pclk);
    run <= 1'b1;
    rep_issue <= 1'b1;
    rep_use_wreg <= 1'b1;
    working_register_operand <= 16'hC020;
    @(posedge pclk);
    rep_issue <= 1'b0;
    #1 chk({repeat_active_flag, pc_hold}, 2'b11);
    apb(1, RLC_ADDR_STATUS, 32'h0);
    apb(0, RLC_ADDR_STATUS, 0);
    chk(rd[RLC_RA_BIT], 1);
    n = 0;
    while (repeat_active_flag !== 1'b0 && n < 60)
    begin
      @(posedge pclk);
      #1 n++;
    end
    chk({passes, pc_hold}, {16'h0020, 1'b0});
    apb(0, RLC_ADDR_REPEAT_LOOP_COUNT, 0);
    chk(rd, 0);
    $display("test repeat done");
    @(posedge pclk);
    run <= 1'b0;
    rep_issue <= 1'b1;
    rep_use_wreg <= 1'b0;
    immediate_count_field <= 14'h0000;
    @(posedge pclk);
    rep_issue <= 1'b0;
    #1 chk(repeat_active_flag, 0);
    @(posedge pclk);
    rep_issue <= 1'b1;
    immediate_count_field <= 14'h3FFF;
    @(posedge pclk);
    rep_issue <= 1'b0;
    apb(0, RLC_ADDR_REPEAT_LOOP_COUNT, 0);
    chk(rd, 32'h3FFF);
    intr_ret(1);
    @(posedge pclk);
    b_tgt <= 1'b1;
    tgt_is_psv <= 1'b1;
    @(posedge pclk);
    #1 chk(psv_stall, 1);
    @(posedge pclk);
    b_tgt <= 1'b0;
    tgt_is_psv <= 1'b0;
    #1 chk(psv_stall, 0);
    intr_ret(0);
    $display("test interrupt done");
    for (int r = 3; r < 5; r++)
    begin
      @(posedge pclk);
      xw_valid <= 1'b1;
      xw_reg <= 4'h3;
      @(posedge pclk);
      xw_valid <= 1'b0;
      xr_valid <= 1'b1;
      xr_reg <= r[3:0];
      @(posedge pclk);
      xr_valid <= 1'b0;
      #1 chk(dep_stall, r == 3);
    end
    for (int p = 0; p < 2; p++)
    begin
      @(posedge pclk);
      ret_sub <= 1'b1;
      ret_sub_pc <= p ? 24'h03FFFC : 24'h03FFFA;
      @(posedge pclk);
      ret_sub <= 1'b0;
      #1 chk(addr_err_trap, p);
    end
    @(posedge pclk);
    do_issue <= 1'b1;
    do_use_wreg <= 1'b1;
    working_register_operand <= 16'hC001;
    pc_in <= 24'h000100;
    do_end_in <= 24'h000108;
    @(posedge pclk);
    do_issue <= 1'b0;
    #1 chk(do_active, 1);
    apb(0, RLC_ADDR_MULTI_LOOP_COUNT, 0);
    chk(rd, 1);
    apb(0, RLC_ADDR_DSTART, 0);
    chk(rd, 32'h00000102);
    apb(0, RLC_ADDR_DEND, 0);
    chk(rd, 32'h00000108);
    for (int i = 0; i < 2; i++)
    begin
      @(posedge pclk);
      pc_in <= 24'h000108;
      pc_valid <= 1'b1;
      @(posedge pclk);
      pc_valid <= 1'b0;
      #1 chk({do_reload, do_active}, i ? 2'b00 : 2'b11);
    end
    chk(do_reload_pc, 24'h000102);
    $display("test loops done");
    results();
  end
endmodule // rlc_repeat_loop_controller_bench
